/* core/sbp_regs_pkg.sv */
// Package: register map, field layout and timing constants
// Function
// - Sixteen registers: base 0-7, paged 8-Fh
// - Page number field in register 7 selects page
// - Reserved registers and fields read zero
// - Pages 2 through 6 are reserved
// - Six-bit node address set by self-ID
// - Root flag cleared by bus reset, set by tree-ID
// - Cable power flag mirrors sense input
// - Root holdoff kept across bus resets
// - Long reset request waits, then 166 us reset
// - Gap setting, 3Fh after two idle resets
// - Extended field 111b, port count 00010b
// - Speed capability reads 010b
// - Repeater delay field reads zero
// - Repeater jitter field reads zero
// - Self-ID link bit is control AND status
// - Link-active control set by hardware reset
// - Link interface governed by power status only
// - Contender bit from pin, to self-ID bit 20
// - Power class from pins, self-ID bits 21-23
// - Resume enable gates resume event, and wake from all flags but port event
// - Short reset request starts 1.30 us reset
// - Config timeout flag, write one clears
// - State timeout flag, also forces bus reset
// - Port event flag, wakes inactive link
package sbp_regs_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_NODE_ID_STATUS = 4'h0;
   localparam logic [3:0] ADDR_RESET_GAP_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_PORT_CAPABILITY = 4'h2;
   localparam logic [3:0] ADDR_SPEED_DELAY_INFO = 4'h3;
   localparam logic [3:0] ADDR_LINK_POWER_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_INTERRUPT_ARB_CONTROL = 4'h5;
   localparam logic [3:0] ADDR_RESERVED_SLOT = 4'h6;
   localparam logic [3:0] ADDR_PAGE_PORT_SELECT = 4'h7;
   // ------------------------------------------------------------
   // Field layout (bit 0 is the register MSB)
   // ------------------------------------------------------------
   localparam int BIT_ROOT = 6;
   localparam int BIT_CABLE_POWER = 7;
   localparam int BIT_ROOT_HOLDOFF = 0;
   localparam int BIT_LONG_RESET = 1;
   localparam int BIT_LINK_ACTIVE = 0;
   localparam int BIT_CONTENDER = 1;
   localparam int BIT_RESUME_IE = 0;
   localparam int BIT_SHORT_RESET = 1;
   localparam int BIT_CONFIG_TO = 2;
   localparam int BIT_CABLE_DROP = 3;
   localparam int BIT_STATE_TO = 4;
   localparam int BIT_PORT_EVENT = 5;
   localparam int BIT_ACCEL_ARB = 6;
   localparam int BIT_MULTI_SPEED = 7;
   localparam int PAGE_LSB = 5;
   localparam int PORT_SEL_MASK_W = 4;
   // ------------------------------------------------------------
   // Fixed values and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] EXTENDED_SET = 3'h7;
   localparam logic [4:0] PORT_COUNT = 5'h02;
   localparam logic [2:0] SPEED_S400 = 3'h2;
   localparam logic [3:0] REPEATER_DELAY = 4'h0;
   localparam logic [2:0] REPEATER_JITTER = 3'h0;
   localparam logic [5:0] GAP_DEFAULT = 6'h3F;
   localparam logic [2:0] FIRST_RSVD_PAGE = 3'h2;
   localparam logic [2:0] LAST_RSVD_PAGE = 3'h6;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // ------------------------------------------------------------
   // Bus reset timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int LONG_RESET_PS = 166000000;
   localparam int SHORT_RESET_PS = 1300000;
   localparam int LONG_RESET_CYCLES = LONG_RESET_PS / CLK_PERIOD_PS;
   localparam int SHORT_RESET_CYCLES =
      (SHORT_RESET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

/* core/sbp_bus_reset_timer.sv */
// Bus reset generator: runs one long or short reset pulse
`timescale 1ns/1ps
module sbp_bus_reset_timer
#(
   parameter int LONG_CYCLES = sbp_regs_pkg::LONG_RESET_CYCLES,
   parameter int SHORT_CYCLES = sbp_regs_pkg::SHORT_RESET_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requests
   input wire logic start_long,
   input wire logic start_short,
   // Status
   output logic active,
   output logic done
);
   typedef enum logic [1:0] {SBR_IDLE, SBR_RUN, SBR_END} sbr_state_t;
   sbr_state_t state;
   logic [22:0] count;

   assign active = (state == SBR_RUN);
   assign done = (state == SBR_END);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= SBR_IDLE;
         count <= '0;
      end
      else
      begin
         unique case (state)
            SBR_IDLE:
            begin
               // Long wins: a short request merged into a long is harmless
               if (start_long)
               begin
                  count <= 23'(LONG_CYCLES - 1);
                  state <= SBR_RUN;
               end
               else if (start_short)
               begin
                  count <= 23'(SHORT_CYCLES - 1);
                  state <= SBR_RUN;
               end
            end
            SBR_RUN:
            begin
               if (count == '0)
                  state <= SBR_END;
               else
                  count <= count - 23'h1;
            end
            SBR_END:
               state <= SBR_IDLE;
         endcase
      end
   end
endmodule

/* core/sbp_base_regs.sv */
// Base register bank of the serial bus physical layer section
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module sbp_base_regs
#(
   parameter int LONG_CYCLES = sbp_regs_pkg::LONG_RESET_CYCLES,
   parameter int SHORT_CYCLES = sbp_regs_pkg::SHORT_RESET_CYCLES
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Paged window data from page logic
   input wire logic [7:0] PAGE_RDATA,
   output logic PAGE_WR,
   // Pins
   input wire logic CABLE_POWER_SENSE,
   input wire logic LINK_POWER_STATUS,
   input wire logic BUS_MANAGER_CANDIDATE_PIN,
   input wire logic [2:0] POWER_CLASS_PINS,
   output logic LINK_WAKE_OUTPUT,
   // Arbitration events
   input wire logic SELF_ID_DONE,
   input wire logic [5:0] SELF_ID_ADDR,
   input wire logic TREE_ID_ROOT,
   input wire logic CONFIG_PACKET,
   input wire logic [5:0] CONFIG_GAP,
   input wire logic CONFIG_TIMEOUT,
   input wire logic STATE_TIMEOUT,
   input wire logic PORT_CHANGE,
   input wire logic RESUME_START,
   input wire logic LINE_BUSY,
   // Self-ID fields and arbitration controls
   output logic SELF_ID_LINK_ACTIVE,
   output logic SELF_ID_CONTENDER,
   output logic [2:0] SELF_ID_POWER_CLASS,
   output logic [5:0] GAP_COUNT,
   output logic ROOT_HOLDOFF,
   output logic ACCEL_ARB,
   output logic MULTI_SPEED,
   output logic LINK_IF_ENABLE,
   output logic BUS_RESET_ACTIVE,
   output logic NODE_ADDR_VALID,
   output logic [2:0] PORT_SELECT
);
   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic rst_meta, rst_n;
   logic [5:0] pin_meta, pin_sync;
   logic cable_power_flag, link_power_status, cable_power_prev;
   logic strap_pending;
   logic [1:0] strap_wait;

   always_ff @(posedge SYS_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= {CABLE_POWER_SENSE, LINK_POWER_STATUS,
                      BUS_MANAGER_CANDIDATE_PIN, POWER_CLASS_PINS};
         pin_sync <= pin_meta;
      end
   end

   assign cable_power_flag = pin_sync[5];
   assign link_power_status = pin_sync[4];
   assign LINK_IF_ENABLE = link_power_status;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [5:0] node_address_field;
   logic root;
   logic root_holdoff, long_reset_request, short_reset_request;
   logic [5:0] gap;
   logic gap_touched;
   logic link_active_control, contender;
   logic [2:0] power_class;
   logic resume_interrupt_enable;
   logic config_timeout_flag, cable_power_drop_flag;
   logic state_timeout_flag, port_event_flag;
   logic accel_arb, multi_speed;
   logic [2:0] page;
   logic [3:0] port_sel;
   logic addr_valid;
   logic link_active;
   logic bus_reset_done, bus_reset_active;
   logic start_long, start_short;

   function automatic logic wr_at(input logic [3:0] a);
      wr_at = WR && (ADDR == a);
   endfunction

   function automatic logic clear_bit(input int pos);
      clear_bit = wr_at(sbp_regs_pkg::ADDR_INTERRUPT_ARB_CONTROL)
                  && WDATA[7 - pos];
   endfunction

   assign PAGE_WR = WR && ADDR[3];
   assign link_active = link_active_control && link_power_status;

   // ------------------------------------------------------------
   // Bus reset sequencing
   // ------------------------------------------------------------
   // Long request waits for line idle; state timeout forces a reset
   assign start_long = !bus_reset_active && !bus_reset_done
                       && ((long_reset_request && !LINE_BUSY)
                           || STATE_TIMEOUT);
   assign start_short = !bus_reset_active && !bus_reset_done
                        && short_reset_request && !LINE_BUSY;

   sbp_bus_reset_timer #(
      .LONG_CYCLES(LONG_CYCLES),
      .SHORT_CYCLES(SHORT_CYCLES)
   ) u_timer (
      .clk(SYS_CLK),
      .rst_n(rst_n),
      .start_long(start_long),
      .start_short(start_short),
      .active(bus_reset_active),
      .done(bus_reset_done)
   );

   assign BUS_RESET_ACTIVE = bus_reset_active;

   // ------------------------------------------------------------
   // Identity and root
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         node_address_field <= '0;
         NODE_ADDR_VALID <= 1'b0;
      end
      else if (bus_reset_active)
         NODE_ADDR_VALID <= 1'b0;
      else if (SELF_ID_DONE)
      begin
         node_address_field <= SELF_ID_ADDR;
         NODE_ADDR_VALID <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
         root <= 1'b0;
      else if (bus_reset_active)
         root <= 1'b0;
      else if (TREE_ID_ROOT)
         root <= 1'b1;
   end

   // ------------------------------------------------------------
   // Reset requests and root holdoff
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         root_holdoff <= 1'b0;
         long_reset_request <= 1'b0;
      end
      else
      begin
         if (wr_at(sbp_regs_pkg::ADDR_RESET_GAP_CONTROL))
            root_holdoff <= WDATA[7 - sbp_regs_pkg::BIT_ROOT_HOLDOFF];
         if (bus_reset_active)
            long_reset_request <= 1'b0;
         else if (wr_at(sbp_regs_pkg::ADDR_RESET_GAP_CONTROL))
            long_reset_request <= WDATA[7 - sbp_regs_pkg::BIT_LONG_RESET];
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
         short_reset_request <= 1'b0;
      else if (bus_reset_active)
         short_reset_request <= 1'b0;
      else if (wr_at(sbp_regs_pkg::ADDR_INTERRUPT_ARB_CONTROL))
         short_reset_request <= WDATA[7 - sbp_regs_pkg::BIT_SHORT_RESET];
   end

   // ------------------------------------------------------------
   // Gap count
   // ------------------------------------------------------------
   // Two finished resets with no update in between restore the default
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap <= sbp_regs_pkg::GAP_DEFAULT;
         gap_touched <= 1'b0;
      end
      else if (wr_at(sbp_regs_pkg::ADDR_RESET_GAP_CONTROL))
      begin
         gap <= WDATA[5:0];
         gap_touched <= 1'b1;
      end
      else if (CONFIG_PACKET)
      begin
         gap <= CONFIG_GAP;
         gap_touched <= 1'b1;
      end
      else if (bus_reset_done)
      begin
         // The reset after an update keeps it, the next one restores
         gap_touched <= 1'b0;
         if (!gap_touched)
            gap <= sbp_regs_pkg::GAP_DEFAULT;
      end
   end

   // ------------------------------------------------------------
   // Link power and self-ID configuration
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_active_control <= 1'b1;
         strap_pending <= 1'b1;
         strap_wait <= '1;
         contender <= 1'b0;
         power_class <= '0;
      end
      // Two edges for the pin synchronisers to fill after release
      else if (strap_wait[0])
         strap_wait <= {1'b0, strap_wait[1]};
      else if (strap_pending)
      begin
         // Straps caught once the synchronisers hold real pin levels
         strap_pending <= 1'b0;
         contender <= pin_sync[3];
         power_class <= pin_sync[2:0];
      end
      else if (wr_at(sbp_regs_pkg::ADDR_LINK_POWER_CONFIG))
      begin
         link_active_control <= WDATA[7 - sbp_regs_pkg::BIT_LINK_ACTIVE];
         contender <= WDATA[7 - sbp_regs_pkg::BIT_CONTENDER];
         power_class <= WDATA[2:0];
      end
   end

   // ------------------------------------------------------------
   // Interrupt flags, enables and page select
   // ------------------------------------------------------------
   // Hardware set beats a same-cycle write-one clear
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         config_timeout_flag <= 1'b0;
         cable_power_drop_flag <= 1'b1;
         state_timeout_flag <= 1'b0;
         port_event_flag <= 1'b0;
         cable_power_prev <= 1'b0;
      end
      else
      begin
         cable_power_prev <= cable_power_flag;
         if (CONFIG_TIMEOUT)
            config_timeout_flag <= 1'b1;
         else if (clear_bit(sbp_regs_pkg::BIT_CONFIG_TO))
            config_timeout_flag <= 1'b0;
         if (cable_power_prev && !cable_power_flag)
            cable_power_drop_flag <= 1'b1;
         else if (clear_bit(sbp_regs_pkg::BIT_CABLE_DROP))
            cable_power_drop_flag <= 1'b0;
         if (STATE_TIMEOUT)
            state_timeout_flag <= 1'b1;
         else if (clear_bit(sbp_regs_pkg::BIT_STATE_TO))
            state_timeout_flag <= 1'b0;
         if (PORT_CHANGE || (RESUME_START && resume_interrupt_enable))
            port_event_flag <= 1'b1;
         else if (clear_bit(sbp_regs_pkg::BIT_PORT_EVENT))
            port_event_flag <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resume_interrupt_enable <= 1'b0;
         accel_arb <= 1'b0;
         multi_speed <= 1'b0;
         page <= '0;
         port_sel <= '0;
      end
      else
      begin
         if (wr_at(sbp_regs_pkg::ADDR_INTERRUPT_ARB_CONTROL))
         begin
            resume_interrupt_enable <=
               WDATA[7 - sbp_regs_pkg::BIT_RESUME_IE];
            accel_arb <= WDATA[7 - sbp_regs_pkg::BIT_ACCEL_ARB];
            multi_speed <= WDATA[7 - sbp_regs_pkg::BIT_MULTI_SPEED];
         end
         if (wr_at(sbp_regs_pkg::ADDR_PAGE_PORT_SELECT))
         begin
            page <= WDATA[7:sbp_regs_pkg::PAGE_LSB];
            port_sel <= WDATA[sbp_regs_pkg::PORT_SEL_MASK_W-1:0];
         end
      end
   end

   // Wake line: port event alone, others need the resume enable
   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
         LINK_WAKE_OUTPUT <= 1'b0;
      else
         LINK_WAKE_OUTPUT <= !link_active
            && (port_event_flag
                || (resume_interrupt_enable
                    && (config_timeout_flag || cable_power_drop_flag
                        || state_timeout_flag)));
   end

   // ------------------------------------------------------------
   // Outputs to arbitration and self-ID
   // ------------------------------------------------------------
   assign SELF_ID_LINK_ACTIVE = link_active;
   assign SELF_ID_CONTENDER = contender;
   assign SELF_ID_POWER_CLASS = power_class;
   assign GAP_COUNT = gap;
   assign ROOT_HOLDOFF = root_holdoff;
   assign ACCEL_ARB = accel_arb;
   assign MULTI_SPEED = multi_speed;
   assign PORT_SELECT = port_sel[2:0];

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Reserved pages and slots return zero
   assign addr_valid = !(page >= sbp_regs_pkg::FIRST_RSVD_PAGE
                         && page <= sbp_regs_pkg::LAST_RSVD_PAGE);

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
         RDATA <= sbp_regs_pkg::ZERO_BYTE;
      else if (!RD)
         RDATA <= sbp_regs_pkg::ZERO_BYTE;
      else if (ADDR[3])
         RDATA <= addr_valid ? PAGE_RDATA : sbp_regs_pkg::ZERO_BYTE;
      else
      begin
         unique case (ADDR[2:0])
            sbp_regs_pkg::ADDR_NODE_ID_STATUS[2:0]:
               RDATA <= {node_address_field, root, cable_power_flag};
            sbp_regs_pkg::ADDR_RESET_GAP_CONTROL[2:0]:
               RDATA <= {root_holdoff, long_reset_request, gap};
            sbp_regs_pkg::ADDR_PORT_CAPABILITY[2:0]:
               RDATA <= {sbp_regs_pkg::EXTENDED_SET,
                         sbp_regs_pkg::PORT_COUNT};
            sbp_regs_pkg::ADDR_SPEED_DELAY_INFO[2:0]:
               RDATA <= {sbp_regs_pkg::SPEED_S400, 1'b0,
                         sbp_regs_pkg::REPEATER_DELAY};
            sbp_regs_pkg::ADDR_LINK_POWER_CONFIG[2:0]:
               RDATA <= {link_active_control, contender,
                         sbp_regs_pkg::REPEATER_JITTER,
                         power_class};
            sbp_regs_pkg::ADDR_INTERRUPT_ARB_CONTROL[2:0]:
               RDATA <= {resume_interrupt_enable, short_reset_request,
                         config_timeout_flag, cable_power_drop_flag,
                         state_timeout_flag, port_event_flag,
                         accel_arb, multi_speed};
            sbp_regs_pkg::ADDR_RESERVED_SLOT[2:0]:
               RDATA <= sbp_regs_pkg::ZERO_BYTE;
            sbp_regs_pkg::ADDR_PAGE_PORT_SELECT[2:0]:
               RDATA <= {page, 1'b0, port_sel};
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_root_bus_clear: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      bus_reset_active |=> !root)
      else $error("root flag survived bus reset");
   a_short_req_clear: assert property (@(posedge SYS_CLK)
      disable iff (!rst_n) bus_reset_active |=> !short_reset_request)
      else $error("short reset request not cleared");
   a_long_req_clear: assert property (@(posedge SYS_CLK)
      disable iff (!rst_n) bus_reset_active |=> !long_reset_request)
      else $error("long reset request not cleared");
   a_link_bit_and: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      SELF_ID_LINK_ACTIVE == (link_active_control && link_power_status))
      else $error("self-ID link bit wrong");
   a_timeout_resets: assert property (@(posedge SYS_CLK)
      disable iff (!rst_n) STATE_TIMEOUT && !bus_reset_active
      && !bus_reset_done |=> bus_reset_active)
      else $error("state timeout gave no bus reset");
   a_cto_set_wins: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      CONFIG_TIMEOUT |=> config_timeout_flag)
      else $error("config timeout flag lost");
   a_pei_wake: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      port_event_flag && !link_active |=> LINK_WAKE_OUTPUT)
      else $error("wake missing on port event");
   a_rsvd_page_zero: assert property (@(posedge SYS_CLK)
      disable iff (!rst_n) RD && ADDR[3] && !addr_valid
      |=> RDATA == sbp_regs_pkg::ZERO_BYTE)
      else $error("reserved page read nonzero");
   a_caps_fixed: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      RD && ADDR == sbp_regs_pkg::ADDR_PORT_CAPABILITY
      |=> RDATA == 8'hE2)
      else $error("capability register wrong");
   a_speed_fixed: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
      RD && ADDR == sbp_regs_pkg::ADDR_SPEED_DELAY_INFO
      |=> RDATA == 8'h40)
      else $error("speed register wrong");
endmodule

/* verification/sbp_link_model.sv */
// Link layer model: power status that answers the wake output
`timescale 1ns/1ps
module sbp_link_model
#(
   parameter int WAKE_DELAY = 3
)
(
   // Clock
   input wire logic clk,
   // Control from the bench and wake from the block
   input wire logic power_on,
   input wire logic wake,
   // Power status toward the block
   output logic link_power_status
);
   int cnt = 0;
   logic woke = 1'b0;
   assign link_power_status = power_on | woke;
   // Slow power-up: a real link needs time to restart its clocks
   always_ff @(posedge clk)
   begin
      cnt <= (wake && !link_power_status) ? cnt + 1 : 0;
      if (cnt == WAKE_DELAY)
         woke <= 1'b1;
      else if (power_on)
         woke <= 1'b0;
   end
endmodule

/* verification/sbp_base_regs_tb.sv */
// Testbench for the base register bank
`timescale 1ns/1ps
module sbp_base_regs_tb;
   logic SYS_CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, lps_cmd = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00, PAGE_RDATA = 8'h00, RDATA;
   logic CABLE_POWER_SENSE = 1'b1, BUS_MANAGER_CANDIDATE_PIN = 1'b0;
   logic [2:0] POWER_CLASS_PINS = 3'h0, SELF_ID_POWER_CLASS, PORT_SELECT;
   // Event strobes, raised for one cycle by pulse() through their index
   logic [6:0] ev = 7'h00;
   logic LINE_BUSY = 1'b0;
   wire logic CONFIG_TIMEOUT = ev[0], STATE_TIMEOUT = ev[1];
   wire logic PORT_CHANGE = ev[2], CONFIG_PACKET = ev[3];
   wire logic TREE_ID_ROOT = ev[4], SELF_ID_DONE = ev[5];
   wire logic RESUME_START = ev[6];
   logic [5:0] SELF_ID_ADDR = 6'h00, CONFIG_GAP = 6'h00, GAP_COUNT, g;
   logic PAGE_WR, LINK_WAKE_OUTPUT, SELF_ID_LINK_ACTIVE, SELF_ID_CONTENDER;
   logic ROOT_HOLDOFF, ACCEL_ARB, MULTI_SPEED, LINK_IF_ENABLE;
   logic BUS_RESET_ACTIVE, NODE_ADDR_VALID, LINK_POWER_STATUS;
   int errors = 0, comparisons = 0, cycles = 0;
   logic [7:0] v;
   // Long reset shortened so the run stays brief
   sbp_base_regs #(.LONG_CYCLES(20)) dut (.*);
   sbp_link_model link (.clk(SYS_CLK), .power_on(lps_cmd),
      .wake(LINK_WAKE_OUTPUT), .link_power_status(LINK_POWER_STATUS));
   always #12.5 SYS_CLK = ~SYS_CLK;
   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask
   task automatic pulse(input int k);
      @(posedge SYS_CLK);
      ev[k] <= 1'b1;
      @(posedge SYS_CLK);
      ev[k] <= 1'b0;
   endtask
   // Flag expected in register 5 after event i of the flag scenario
   function automatic logic [7:0] flag_bit(input int i);
      flag_bit = (i == 2) ? 8'h04 : 8'h20 >> (2 * i);
   endfunction
   task automatic wait_reset();
      int n;
      n = 0;
      while (BUS_RESET_ACTIVE !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      chk({7'h00, BUS_RESET_ACTIVE}, 8'h01);
      while (BUS_RESET_ACTIVE === 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
      tick(2);
   endtask
   task automatic print_verdict();
      if (errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hang counts as a mismatch
   always @(posedge SYS_CLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         print_verdict();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(83176));
      POWER_CLASS_PINS = 3'($urandom);
      BUS_MANAGER_CANDIDATE_PIN = 1'($urandom);
      repeat (16) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      tick(6);
      rd(2); chk(v, 8'hE2);
      rd(3); chk(v, 8'h40);
      rd(1); chk(v, 8'h3F);
      rd(0); chk(v & 8'h03, 8'h01);
      chk({5'h00, SELF_ID_POWER_CLASS}, {5'h00, POWER_CLASS_PINS});
      chk({7'h00, SELF_ID_CONTENDER}, {7'h00, BUS_MANAGER_CANDIDATE_PIN});
      chk({7'h00, SELF_ID_LINK_ACTIVE}, 8'h01);
      wr(4, 8'h00); tick(1);
      chk({6'h00, SELF_ID_LINK_ACTIVE, LINK_IF_ENABLE}, 8'h01);
      wr(4, 8'h80); wr(0, 8'hFF); wr(2, 8'h00); wr(6, 8'hFF);
      rd(2); chk(v, 8'hE2);
      rd(6); chk(v, 8'h00);
      rd(0); chk(v, 8'h01);
      CABLE_POWER_SENSE <= 1'b0; tick(4);
      rd(0); chk(v & 8'h01, 8'h00);
      for (int pg = 0; pg < 8; pg++)
      begin
         wr(7, {3'(pg), 2'h0, 3'(pg)});
         PAGE_RDATA <= 8'($urandom);
         rd(4'h8 | 4'($urandom));
         chk(v, (pg >= 2 && pg <= 6) ? 8'h00 : PAGE_RDATA);
         rd(7); chk(v & 8'hE0, {3'(pg), 5'h00});
         chk({5'h00, PORT_SELECT}, {5'h00, 3'(pg)});
      end
      for (int i = 0; i < 3; i++)
      begin
         pulse(i);
         if (i == 1)
            wait_reset();
         rd(5); chk(v & 8'h2C, flag_bit(i));
         wr(5, 8'h2C); rd(5); chk(v & 8'h2C, 8'h00);
      end
      g = 6'($urandom); CONFIG_GAP <= g; pulse(3); tick(1);
      chk({2'h0, GAP_COUNT}, {2'h0, g});
      pulse(4); SELF_ID_ADDR <= 6'($urandom); pulse(5);
      rd(0); chk(v & 8'hFE, {SELF_ID_ADDR, 2'b10});
      chk({7'h00, NODE_ADDR_VALID}, 8'h01);
      g = 6'($urandom); LINE_BUSY <= 1'b1; wr(1, {2'b11, g}); tick(10);
      chk({7'h00, BUS_RESET_ACTIVE}, 8'h00);
      LINE_BUSY <= 1'b0; wait_reset();
      rd(0); chk(v & 8'h02, 8'h00);
      rd(1); chk(v, {2'b10, g});
      chk({7'h00, ROOT_HOLDOFF}, 8'h01);
      wr(5, 8'h40); wait_reset();
      rd(5); chk(v & 8'h40, 8'h00);
      rd(1); chk(v, 8'hBF);
      lps_cmd <= 1'b0; tick(6); pulse(2); tick(2);
      chk({7'h00, LINK_WAKE_OUTPUT}, 8'h01);
      tick(12);
      chk({6'h00, LINK_WAKE_OUTPUT, LINK_IF_ENABLE}, 8'h01);
      lps_cmd <= 1'b1; wr(5, 8'h04); pulse(6);
      rd(5); chk(v & 8'h04, 8'h00);
      wr(5, 8'h83); pulse(6);
      rd(5); chk(v & 8'h84, 8'h84);
      chk({6'h00, ACCEL_ARB, MULTI_SPEED}, 8'h03);
      print_verdict();
   end
endmodule
